// >>> hw/dwl_core.sv
// write leveling feedback and mode register logic of the dram device
// Overview of operation
// [RULE1] clock changes only in self refresh/power-down
// [RULE2] self refresh change respects tCKSRE, tCKSRX
// [RULE3] power-down change: termination off, cke low
// [RULE4] wait tCKSRE after cke low, hold low
// [RULE5] stable clock, exit, then dll reset
// [RULE6] termination off while dll relocks
// [RULE7] dqs rise samples ck onto prime dq
// [RULE8] other dq driven low while leveling
// [RULE9] mode register 1 bit 7 enables leveling
// [RULE10] bit 12 set: ignore dqs, dq floating
// [RULE11] odt terminates only dqs while leveling
// [RULE12] termination values limited when outputs on
// [RULE13] only nop/deselect, controller not driving dq
// [RULE14] level one rank, disable others' outputs
// [RULE15] odt after tMOD, before dqs low
// [RULE16] dqs low after tWLDQSEN, toggle after tWLMRD
// [RULE17] odt latency met before first toggle
// [RULE18] toggles keep minimum pulse widths only
// [RULE19] controller locks delay at 0-to-1 transition
// [RULE20] stop dqs after tWLO max plus margin
// [RULE21] odt off after dqs stops, then exit
// [RULE22] after exit dq undefined until tMOD
// [RULE23] dll reset bit self clears, others persist
`timescale 1ns/1ps
module dwl_core (
  input  wire logic                      core_clk_in,   // 10 MHz core clock
  input  wire logic                      reset_n_in,    // sync reset, low active
  input  wire logic                      psel_in,       // apb select
  input  wire logic                      penable_in,    // apb access phase
  input  wire logic                      pwrite_in,     // apb direction
  input  wire logic [11:0]               paddr_in,      // apb byte address
  input  wire logic [31:0]               pwdata_in,     // apb write data
  output logic      [31:0]               prdata_out,    // apb read data
  output logic                           pready_out,    // apb ready
  output logic                           pslverr_out,   // apb error
  input  wire dwl_pkg::dwl_cmd_t         cmd_pins_in,   // command pins
  input  wire logic                      cke_in,        // clock enable pin
  input  wire logic                      odt_in,        // termination pin
  input  wire logic                      ck_in,         // memory clock level
  input  wire logic                      dqs_in,        // strobe pin
  output logic      [dwl_pkg::DQ_W-1:0]  dq_out,        // data pin drive value
  output logic                           dq_oe_out,     // data pin drive enable
  output logic                           dqs_term_out,  // strobe termination on
  output logic                           dq_term_out,   // data termination on
  output logic                           dll_locked_out // dll relock finished
);

  // ==========================================================================
  // pin synchronisation
  // ==========================================================================
  localparam int PW = $bits(dwl_pkg::dwl_cmd_t) + 4;    // all pins in one bundle

  logic [PW-1:0]         pins_s;                        // filtered pins
  dwl_pkg::dwl_cmd_t     cmd_s;                         // filtered command
  logic                  cke_s;                         // filtered cke
  logic                  odt_s;                         // filtered odt
  logic                  ck_s;                          // filtered clock level
  logic                  dqs_s;                         // filtered strobe

  dwl_pin_sync #(.W(PW)) u_sync (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .pins_in     ({cmd_pins_in, cke_in, odt_in, ck_in, dqs_in}),
    .pins_out    (pins_s)
  );

  assign {cmd_s, cke_s, odt_s, ck_s, dqs_s} = pins_s;

  // ==========================================================================
  // command capture and mode registers
  // ==========================================================================
  logic                  mrs_prev_r;                    // mrs seen last cycle
  logic                  dqs_prev_r;                    // strobe last cycle
  logic                  mrs_take;                      // one pulse per command
  logic                  dqs_rise;                      // strobe rising edge
  logic [15:0]           mr_r [4];                      // mode registers 0..3
  logic [1:0]            mr_sel;                        // addressed register

  // a command held over several core cycles counts once
  assign mrs_take = dwl_pkg::is_mrs(cmd_s) && cke_s && !mrs_prev_r;
  assign dqs_rise = dqs_s && !dqs_prev_r;
  assign mr_sel   = cmd_s.ba[1:0];

  // edge history for command and strobe
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mrs_prev_r <= 1'b0;
      dqs_prev_r <= 1'b0;
    end else begin
      mrs_prev_r <= dwl_pkg::is_mrs(cmd_s) && cke_s;
      dqs_prev_r <= dqs_s;
    end
  end

  // contents persist until rewritten or reset; dll reset bit self clears
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 4; i++) begin
        mr_r[i] <= dwl_pkg::MR_RESET;                    // see [RULE23]
      end
    end else begin
      if (mr_r[0][dwl_pkg::MR0_DLLRST]) begin
        mr_r[0][dwl_pkg::MR0_DLLRST] <= 1'b0;            // see [RULE23]
      end
      if (mrs_take) begin
        mr_r[mr_sel] <= cmd_s.addr;                      // see [RULE23]
      end
    end
  end

  logic                  wl_bit;                        // leveling requested
  logic                  qoff;                          // outputs disabled
  logic                  rtt_nom_en;                    // nominal termination set
  assign wl_bit     = mr_r[1][dwl_pkg::MR1_WL];
  assign qoff       = mr_r[1][dwl_pkg::MR1_QOFF];
  assign rtt_nom_en = mr_r[1][dwl_pkg::MR1_RTT0] | mr_r[1][dwl_pkg::MR1_RTT1] |
                      mr_r[1][dwl_pkg::MR1_RTT2];

  // ==========================================================================
  // mode update window and dll relock timers
  // ==========================================================================
  logic [7:0]            mod_cnt_r;                     // tMOD countdown
  logic [9:0]            dll_cnt_r;                     // tDLLK countdown
  logic                  dll_locked_r;                  // relock finished

  // every mode register write reopens the update window
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mod_cnt_r <= 8'h00;
    end else if (mrs_take) begin
      mod_cnt_r <= 8'(dwl_pkg::TMOD_NCK);
    end else if (mod_cnt_r != 8'h00) begin
      mod_cnt_r <= mod_cnt_r - 8'h01;
    end
  end

  // dll relock starts on the self clearing reset bit; only status, the
  // controller keeps termination off meanwhile (see [RULE6])
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      dll_cnt_r    <= 10'h000;
      dll_locked_r <= 1'b0;
    end else if (mr_r[0][dwl_pkg::MR0_DLLRST]) begin
      dll_cnt_r    <= 10'(dwl_pkg::TDLLK_NCK - 1);      // see [RULE5]
      dll_locked_r <= 1'b0;
    end else if (dll_cnt_r != 10'h000) begin
      dll_cnt_r    <= dll_cnt_r - 10'h001;
    end else begin
      dll_locked_r <= 1'b1;
    end
  end

  // ==========================================================================
  // write leveling state machine
  // ==========================================================================
  dwl_pkg::dwl_state_t   state_r;                       // leveling state
  logic                  wl_on;                         // leveling in force
  logic                  sample_r;                      // last captured ck
  logic [3:0]            prime_r;                       // prime lane (software)
  assign wl_on = (state_r == dwl_pkg::WL_WAIT) || (state_r == dwl_pkg::WL_ACTIVE);

  // entry by bit 7, exit through the tMOD window where dq is undefined
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_r <= dwl_pkg::WL_OFF;
    end else begin
      case (state_r)
        dwl_pkg::WL_OFF: begin
          if (mrs_take && mr_sel == 2'd1 && cmd_s.addr[dwl_pkg::MR1_WL]) begin
            state_r <= dwl_pkg::WL_WAIT;                // see [RULE9]
          end
        end
        dwl_pkg::WL_WAIT, dwl_pkg::WL_ACTIVE: begin
          if (mrs_take && mr_sel == 2'd1 && !cmd_s.addr[dwl_pkg::MR1_WL]) begin
            state_r <= dwl_pkg::WL_SETTLE;              // see [RULE22]
          end else if (dqs_rise && !qoff) begin
            state_r <= dwl_pkg::WL_ACTIVE;              // see [RULE7]
          end
        end
        dwl_pkg::WL_SETTLE: begin
          if (mod_cnt_r == 8'h01) begin
            state_r <= wl_bit ? dwl_pkg::WL_WAIT : dwl_pkg::WL_OFF;
          end
        end
        default: state_r <= dwl_pkg::WL_OFF;
      endcase
    end
  end

  // strobe rising edge captures the clock level; strobes ignored when off
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sample_r <= 1'b0;
    end else if (wl_on && !qoff && dqs_rise) begin
      sample_r <= ck_s;                                  // see [RULE7] [RULE10]
    end
  end

  // ==========================================================================
  // dq drive and termination
  // ==========================================================================
  logic [dwl_pkg::DQ_W-1:0] dq_out_r;                   // data drive value
  logic                     dq_oe_r;                    // data drive enable
  logic                     dqs_term_r;                 // strobe termination
  logic                     dq_term_r;                  // data termination

  // non prime lanes are forced low for the whole procedure; the prime lane
  // follows the capture in the same edge, so the lag is one core cycle
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      dq_out_r  <= '0;
      dq_oe_r   <= 1'b0;
    end else begin
      dq_out_r  <= '0;                                   // see [RULE8]
      dq_oe_r   <= wl_on && !qoff && !(mrs_take && mr_sel == 2'd1 &&
                   !cmd_s.addr[dwl_pkg::MR1_WL]);        // see [RULE10] [RULE22]
      if (wl_on && !qoff) begin
        dq_out_r[prime_r] <= dqs_rise ? ck_s : sample_r; // see [RULE7]
      end
    end
  end

  // while leveling the odt pin reaches only the strobe termination
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      dqs_term_r <= 1'b0;
      dq_term_r  <= 1'b0;
    end else if (wl_on) begin
      dqs_term_r <= odt_s && rtt_nom_en;                 // see [RULE11]
      dq_term_r  <= 1'b0;                                // see [RULE11]
    end else begin
      dqs_term_r <= odt_s && rtt_nom_en && cke_s;
      dq_term_r  <= odt_s && rtt_nom_en && cke_s;
    end
  end

  // ==========================================================================
  // apb slave: one wait state, data latched at the first access edge
  // ==========================================================================
  logic                  pready_r;                      // ready pulse
  logic                  pslverr_r;                     // error flag
  logic [31:0]           prdata_r;                      // read data
  logic [31:0]           rdata;                         // decoded read value
  logic                  hit;                           // address mapped
  logic                  wr_ok;                         // writable address
  logic [31:0]           status;                        // live status word

  always_comb begin
    status = 32'h0000_0000;
    status[dwl_pkg::ST_WL_ON]   = wl_on;
    status[dwl_pkg::ST_QOFF]    = qoff;
    status[dwl_pkg::ST_SAMPLE]  = sample_r;
    status[dwl_pkg::ST_LOCKED]  = dll_locked_r;
    status[dwl_pkg::ST_MODBUSY] = mod_cnt_r != 8'h00;
    status[dwl_pkg::ST_CLKCHG]  = !cke_s;                // see [RULE1] [RULE4]
    status[dwl_pkg::ST_SETTLE]  = state_r == dwl_pkg::WL_SETTLE;
  end

  // address decode; status and shadows are read only
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    wr_ok = 1'b0;
    if (paddr_in == dwl_pkg::REG_CTRL) begin
      rdata = {28'h000_0000, prime_r};
      wr_ok = 1'b1;
    end else if (paddr_in == dwl_pkg::REG_STATUS) begin
      rdata = status;
    end else if (paddr_in == dwl_pkg::REG_MR0) begin
      rdata = {16'h0000, mr_r[0]};
    end else if (paddr_in == dwl_pkg::REG_MR1) begin
      rdata = {16'h0000, mr_r[1]};
    end else begin
      hit = 1'b0;
    end
  end

  // answer: ready rises one cycle into the access phase
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r <= psel_in && penable_in && !pready_r;
      if (psel_in && penable_in && !pready_r) begin
        pslverr_r <= !hit || (pwrite_in && !wr_ok);
        prdata_r  <= pwrite_in ? 32'h0000_0000 : rdata;
      end
    end
  end

  // write lands on the edge where the master sees ready
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      prime_r <= dwl_pkg::CTRL_RESET;
    end else if (psel_in && penable_in && pready_r && pwrite_in &&
                 paddr_in == dwl_pkg::REG_CTRL) begin
      prime_r <= pwdata_in[dwl_pkg::CTRL_PRIME_LSB +: 4];
    end
  end

  assign prdata_out     = prdata_r;
  assign pready_out     = pready_r;
  assign pslverr_out    = pslverr_r;
  assign dq_out         = dq_out_r;
  assign dq_oe_out      = dq_oe_r;
  assign dqs_term_out   = dqs_term_r;
  assign dq_term_out    = dq_term_r;
  assign dll_locked_out = dll_locked_r;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_wl_exit;
    wl_on && mrs_take && mr_sel == 2'd1 && !cmd_s.addr[dwl_pkg::MR1_WL];
  endsequence

  sequence s_settle_hold;
    (state_r == dwl_pkg::WL_SETTLE && !dq_oe_r) [*8];
  endsequence

  chk_wl_entry: assert property ( // see [RULE9]
    (state_r == dwl_pkg::WL_OFF && mrs_take && mr_sel == 2'd1 &&
     cmd_s.addr[dwl_pkg::MR1_WL]) |=> state_r == dwl_pkg::WL_WAIT)
    else $error("leveling not entered after bit 7 set");

  chk_prime_sample: assert property ( // see [RULE7]
    (wl_on && !qoff && dqs_rise && $stable(prime_r) &&
     !(mrs_take && mr_sel == 2'd1 && !cmd_s.addr[dwl_pkg::MR1_WL]))
    |=> dq_oe_r && dq_out_r[prime_r] == $past(ck_s))
    else $error("prime dq does not show sampled clock");

  chk_others_low: assert property ( // see [RULE8]
    dq_oe_r |-> (dq_out_r & ~(16'h0001 << prime_r)) == 16'h0000)
    else $error("non prime dq not low");

  chk_qoff_quiet: assert property ( // see [RULE10]
    (wl_on && qoff) |=> !dq_oe_r && $stable(sample_r))
    else $error("outputs or capture active with buffers off");

  chk_dq_unterm: assert property ( // see [RULE11]
    wl_on |=> !dq_term_r)
    else $error("dq terminated during leveling");

  chk_dqs_term_odt: assert property ( // see [RULE11]
    (wl_on && $past(wl_on) && odt_s && rtt_nom_en) |=> dqs_term_r)
    else $error("strobe termination does not follow odt");

  chk_exit_hiz: assert property ( // see [RULE22]
    s_wl_exit |=> s_settle_hold ##[1:6] state_r != dwl_pkg::WL_SETTLE)
    else $error("dq driven or window wrong after leveling exit");

  chk_dll_clear: assert property ( // see [RULE23]
    mr_r[0][dwl_pkg::MR0_DLLRST] |=> !mr_r[0][dwl_pkg::MR0_DLLRST] && !dll_locked_r)
    else $error("dll reset bit did not self clear");

endmodule // dwl_core

// >>> hw/dwl_pkg.sv
// constants, types and helpers shared by the write leveling device block
package dwl_pkg;

  // ==========================================================================
  // pin widths
  // ==========================================================================
  localparam int DQ_W   = 16;                        // data lanes
  localparam int ADDR_W = 16;                        // command address pins
  localparam int BA_W   = 3;                         // bank address pins
  localparam int PADR_W = 12;                        // apb address width

  // ==========================================================================
  // register offsets (byte addresses)
  // ==========================================================================
  localparam logic [PADR_W-1:0] REG_CTRL   = 12'h000; // prime lane select
  localparam logic [PADR_W-1:0] REG_STATUS = 12'h004; // live state
  localparam logic [PADR_W-1:0] REG_MR0    = 12'h008; // mode register 0 shadow
  localparam logic [PADR_W-1:0] REG_MR1    = 12'h00C; // mode register 1 shadow

  localparam logic [3:0]  CTRL_RESET     = 4'h0;     // prime lane after reset
  localparam int          CTRL_PRIME_LSB = 0;        // prime lane field
  localparam logic [15:0] MR_RESET       = 16'h0000; // mode register reset value

  // status bit positions
  localparam int ST_WL_ON   = 0;                     // leveling in force, outputs may be off
  localparam int ST_QOFF    = 1;                     // output buffers disabled
  localparam int ST_SAMPLE  = 2;                     // last captured clock level
  localparam int ST_LOCKED  = 3;                     // dll relock time elapsed
  localparam int ST_MODBUSY = 4;                     // mode update window open
  localparam int ST_CLKCHG  = 5;                     // cke low, clock may change
  localparam int ST_SETTLE  = 6;                     // exit window, dq undefined

  // ==========================================================================
  // mode register fields
  // ==========================================================================
  localparam int MR0_DLLRST = 8;                     // self clearing dll reset
  localparam int MR1_WL     = 7;                     // write leveling enable
  localparam int MR1_QOFF   = 12;                    // output buffer disable
  localparam int MR1_RTT0   = 2;                     // nominal termination bits
  localparam int MR1_RTT1   = 6;
  localparam int MR1_RTT2   = 9;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;                // core clock period
  localparam int TWLO_MAX_NS   = 9;                  // sample to prime dq, max
  localparam int TWLO_CYC      = (TWLO_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (TWLO_MAX_NS / CLK_PERIOD_NS);
  localparam int TMOD_NCK      = 12;                 // mode update window
  localparam int TDLLK_NCK     = 512;                // dll lock time

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic              cs_n;                         // chip select, low active
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;                           // bank / register select
    logic [ADDR_W-1:0] addr;                         // mode register payload
  } dwl_cmd_t;

  typedef enum logic [1:0] {
    WL_OFF    = 2'b00,                               // normal operation
    WL_WAIT   = 2'b01,                               // entered, no strobe yet
    WL_ACTIVE = 2'b10,                               // sampling clock on strobe
    WL_SETTLE = 2'b11                                // exit window, dq released
  } dwl_state_t;

  // a mode register set is all four command pins low
  function automatic logic is_mrs(input dwl_cmd_t c);
    return !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
  endfunction

endpackage

// >>> hw/dwl_pin_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dwl_pin_sync #(
  parameter int W = 1                                // number of pins
) (
  input  wire logic         core_clk_in,             // core clock
  input  wire logic         reset_n_in,              // sync reset, low active
  input  wire logic [W-1:0] pins_in,                 // raw pins
  output logic      [W-1:0] pins_out                 // filtered levels
);

  // ==========================================================================
  // stages
  // ==========================================================================
  logic [W-1:0] s1_r;                                // metastable stage
  logic [W-1:0] s2_r;                                // second stage
  logic [W-1:0] s3_r;                                // third stage
  logic [W-1:0] hold_r;                              // accepted level

  // shift chain: s1 feeds only s2, never any logic
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      hold_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          hold_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign pins_out = hold_r;

endmodule // dwl_pin_sync

// >>> testbench/dwl_ctrl_model.sv
// controller-side model driving command, clock, termination and strobe pins
`timescale 1ns/1ps
module dwl_ctrl_model (
  input  wire logic         core_clk_in, // shared clock
  output dwl_pkg::dwl_cmd_t cmd_out,     // command pins
  output logic              cke_out,     // clock enable
  output logic              odt_out,     // termination request
  output logic              ck_out,      // memory clock level
  output logic              dqs_out      // strobe
);
  // ==========================================
  // idle levels: deselect, cke high, odt low
  // ==========================================
  initial begin
    cmd_out = '1;
    cke_out = 1'b1;
    odt_out = 1'b0; // termination stays off while dll relocks
    ck_out  = 1'b0;
    dqs_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // command held long enough to pass the pin filter, then deselect only
  task automatic mrs(input logic [2:0] ba, input logic [15:0] v);
    cmd_out <= '{1'b0, 1'b0, 1'b0, 1'b0, ba, v};
    wt(6);
    cmd_out <= '1;
    wt(20);
  endtask
  // one full toggle, wide pulses both ways
  task automatic strobe(input logic lvl);
    ck_out <= lvl;
    wt(6);
    dqs_out <= 1'b1;
    wt(6);
    dqs_out <= 1'b0;
    wt(6);
  endtask
  task automatic odt(input logic v);
    odt_out <= v;
    wt(8);
  endtask
  // power-down with termination off before any clock change
  task automatic pdown(input logic on);
    odt_out <= 1'b0;
    cke_out <= !on;
    wt(8);
  endtask
endmodule // dwl_ctrl_model

// >>> testbench/dwl_core_tb_top.sv
// self-checking bench for the write leveling device block
`timescale 1ns/1ps
module dwl_core_tb_top;
  logic              clk, rst_n, psel, pen, pwr, pready, pslverr, er;
  logic              cke, odt, ck, dqs, dq_oe, dqs_term, dq_term, dll_locked;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [15:0]       dq;
  dwl_pkg::dwl_cmd_t cmd;
  int                fail_count, total_checks, cyc;
  dwl_core dwl_core_i (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cmd_pins_in(cmd),
    .cke_in(cke), .odt_in(odt), .ck_in(ck), .dqs_in(dqs), .dq_out(dq), .dq_oe_out(dq_oe),
    .dqs_term_out(dqs_term), .dq_term_out(dq_term), .dll_locked_out(dll_locked));
  dwl_ctrl_model dwl_ctrl_model_i (.core_clk_in(clk), .cmd_out(cmd), .cke_out(cke),
    .odt_out(odt), .ck_out(ck), .dqs_out(dqs));
  // ==========================================
  // clock, timeout and verdict
  // ==========================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // apb transfer: hold until pready, then release and let one edge pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  // ==========================================
  initial begin
    rst_n <= 1'b0;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, dwl_pkg::REG_MR1, 0);
    chk(rd, 0);
    apb(0, 12'h010, 0);
    chk(er, 1);
    apb(1, dwl_pkg::REG_STATUS, 1);
    chk(er, 1);
    apb(1, dwl_pkg::REG_CTRL, 3);
    apb(0, dwl_pkg::REG_CTRL, 0);
    chk(rd, 3);
    chk(er, 0);
    dwl_ctrl_model_i.mrs(1, 16'h0084);
    chk({dq_oe, dq}, 17'h10000);
    dwl_ctrl_model_i.strobe(1);
    chk(dq, 16'h0008);
    dwl_ctrl_model_i.strobe(0);
    chk(dq, 16'h0000);
    dwl_ctrl_model_i.odt(1);
    chk({dqs_term, dq_term}, 2'b10);
    dwl_ctrl_model_i.odt(0);
    dwl_ctrl_model_i.mrs(1, 16'h0000);
    chk(dq_oe, 0);
    dwl_ctrl_model_i.mrs(1, 16'h1084);
    dwl_ctrl_model_i.strobe(1);
    chk(dq_oe, 0);
    apb(0, dwl_pkg::REG_STATUS, 0);
    chk({rd[dwl_pkg::ST_SAMPLE], rd[dwl_pkg::ST_QOFF], rd[dwl_pkg::ST_WL_ON]}, 3'b011);
    // leave leveling before touching another mode register
    dwl_ctrl_model_i.mrs(1, 16'h0000);
    dwl_ctrl_model_i.mrs(0, 16'h0120);
    apb(0, dwl_pkg::REG_MR0, 0);
    chk(rd, 32'h0020);
    chk(dll_locked, 0);
    repeat (520) @(posedge clk);
    chk(dll_locked, 1);
    dwl_ctrl_model_i.pdown(1);
    apb(0, dwl_pkg::REG_STATUS, 0);
    chk(rd[dwl_pkg::ST_CLKCHG], 1);
    // second reset in mid-run: mode registers and prime lane fall back
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, dwl_pkg::REG_MR0, 0);
    chk(rd, 0);
    apb(0, dwl_pkg::REG_CTRL, 0);
    chk(rd, 0);
    finish_test();
  end
endmodule // dwl_core_tb_top
